// ===== swdp_pkg.sv
// Functional notes
// - pointer is high byte over low byte, both read/write, reset zero.
// - combined pointer drives the external data and program memory address.
// - status bits 5 and 1 are free user flags with no hardware effect.
// - bank field bits 4:3 places R0-R7 at 00h, 08h, 10h or 18h.
// - add overflow set when exactly one of carries from bit 6 and 7.
// - subtract overflow set when exactly one of borrows out of bit 6 and 7.
// - multiply overflow set when the product exceeds 255.
// - divide clears overflow unless divisor was zero, then sets it.
// - parity bit 0 always equals XOR of accumulator bits, read-only.
package swdp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] PTR_LO_IDX = 8'h82;
  localparam logic [7:0] PTR_HI_IDX = 8'h83;
  localparam logic [7:0] STATUS_IDX = 8'hD0;
  localparam logic [31:0] PTR_LO_ADDR = {22'h000000, PTR_LO_IDX, 2'h0};
  localparam logic [31:0] PTR_HI_ADDR = {22'h000000, PTR_HI_IDX, 2'h0};
  localparam logic [31:0] STATUS_ADDR = {22'h000000, STATUS_IDX, 2'h0};
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // status word field positions
  localparam int CARRY_POS = 7;
  localparam int NIB_POS = 6;
  localparam int UFLAG0_POS = 5;
  localparam int BANK_HI_POS = 4;
  localparam int BANK_LO_POS = 3;
  localparam int RANGE_POS = 2;
  localparam int UFLAG1_POS = 1;
  localparam int PARITY_POS = 0;
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  typedef enum logic [2:0] {
    SWDP_OP_ADD = 3'h0,
    SWDP_OP_ADD_CARRY = 3'h1,
    SWDP_OP_SUB_BORROW = 3'h2,
    SWDP_OP_MULT = 3'h3,
    SWDP_OP_DIV = 3'h4
  } swdp_op_t;

  typedef struct packed {
    logic valid;
    swdp_op_t op;
    logic [7:0] a;
    logic [7:0] b;
  } swdp_alu_req_t;
endpackage

// ===== swdp_core.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module swdp_core (
  // clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // core side
  input wire swdp_pkg::swdp_alu_req_t ALU_REQ_IN,
  input wire logic [7:0] ACC_IN,
  input wire logic [2:0] WREG_NUM_IN,
  output logic [15:0] PTR_ADDR_OUT,
  output logic [4:0] WREG_ADDR_OUT,
  output logic [7:0] STATUS_OUT
);
  // word match; byte lanes below bit 2 are ignored
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] reg_addr);
    hit = (addr[31:2] == reg_addr[31:2]);
  endfunction

  // pointer bytes
  logic [7:0] ptr_lo_q;
  logic [7:0] ptr_hi_q;

  // stored status bits; parity is never stored
  logic carry_q;
  logic nib_q;
  logic uf0_q;
  logic [1:0] bank_q;
  logic range_q;
  logic uf1_q;

  // bus data-phase state
  logic [2:0] wsel_q;
  logic [2:0] wsel_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // bus address phase
  wire addr_phase = HSEL_IN && HREADY_IN && (HTRANS_IN == swdp_pkg::HTRANS_NONSEQ);
  wire hit_lo = hit(HADDR_IN, swdp_pkg::PTR_LO_ADDR);
  wire hit_hi = hit(HADDR_IN, swdp_pkg::PTR_HI_ADDR);
  wire hit_st = hit(HADDR_IN, swdp_pkg::STATUS_ADDR);
  // narrow writes are dropped, not merged into a lane
  wire wr_ok = addr_phase && HWRITE_IN && (HSIZE_IN == swdp_pkg::HSIZE_WORD);
  wire rd_ok = addr_phase && !HWRITE_IN;

  // write strobes live in the data phase, while write data stands
  wire wr_lo = wsel_q[0];
  wire wr_hi = wsel_q[1];
  wire wr_st = wsel_q[2];
  wire [7:0] wbyte = HWDATA_IN[7:0];

  wire parity = ^ACC_IN;
  wire [7:0] status = {carry_q, nib_q, uf0_q, bank_q, range_q, uf1_q, parity};

  assign wsel_d = wr_ok ? {hit_st, hit_hi, hit_lo} : 3'h0;

  // loaded at the address phase so it stands through the data phase;
  // parity is the accumulator at that edge, not at the data-phase edge
  assign rdata_d = !rd_ok ? rdata_q :
                   hit_lo ? {24'h000000, ptr_lo_q} :
                   hit_hi ? {24'h000000, ptr_hi_q} :
                   hit_st ? {24'h000000, status} : 32'h00000000;

  // arithmetic operation decode
  wire req_v = ALU_REQ_IN.valid;
  wire [7:0] opa = ALU_REQ_IN.a;
  wire [7:0] opb = ALU_REQ_IN.b;
  wire is_add = (ALU_REQ_IN.op == swdp_pkg::SWDP_OP_ADD);
  wire is_adc = (ALU_REQ_IN.op == swdp_pkg::SWDP_OP_ADD_CARRY);
  wire is_sbb = (ALU_REQ_IN.op == swdp_pkg::SWDP_OP_SUB_BORROW);
  wire is_mult = (ALU_REQ_IN.op == swdp_pkg::SWDP_OP_MULT);
  wire is_div = (ALU_REQ_IN.op == swdp_pkg::SWDP_OP_DIV);

  // stored carry doubles as borrow-in for the subtract
  wire cin = (is_adc || is_sbb) && carry_q;

  // partial sums give the carries out of bits 3, 6 and 7
  wire [8:0] sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  wire [7:0] sum7 = {1'b0, opa[6:0]} + {1'b0, opb[6:0]} + {7'h00, cin};
  wire [4:0] sum4 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  wire [8:0] dif9 = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
  wire [7:0] dif7 = {1'b0, opa[6:0]} - {1'b0, opb[6:0]} - {7'h00, cin};
  wire [4:0] dif4 = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
  wire [15:0] prod = {8'h00, opa} * {8'h00, opb};

  wire adding = is_add || is_adc;
  // codes 5 to 7 fall out here and leave every flag alone
  wire arith = req_v && (adding || is_sbb || is_mult || is_div);
  wire nib_touch = req_v && (adding || is_sbb);

  // carry and borrow out of bit 7
  wire alu_carry = adding ? sum9[8] : is_sbb ? dif9[8] : 1'b0;
  wire alu_nib = adding ? sum4[4] : dif4[4];
  wire rng_add = sum9[8] ^ sum7[7];
  wire rng_sub = dif9[8] ^ dif7[7];
  wire rng_mult = |prod[15:8];
  wire rng_div = (opb == 8'h00);
  wire alu_rng = adding ? rng_add : is_sbb ? rng_sub : is_mult ? rng_mult : rng_div;

  // core updates win over a software write in the same cycle
  wire carry_d = arith ? alu_carry : wr_st ? wbyte[swdp_pkg::CARRY_POS] : carry_q;
  wire nib_d = nib_touch ? alu_nib : wr_st ? wbyte[swdp_pkg::NIB_POS] : nib_q;
  wire range_d = arith ? alu_rng : wr_st ? wbyte[swdp_pkg::RANGE_POS] : range_q;

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      wsel_q <= 3'h0;
      rdata_q <= 32'h00000000;
    end else begin
      wsel_q <= wsel_d;
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      ptr_lo_q <= swdp_pkg::PTR_RST;
      ptr_hi_q <= swdp_pkg::PTR_RST;
    end else begin
      if (wr_lo) begin
        ptr_lo_q <= wbyte;
      end
      if (wr_hi) begin
        ptr_hi_q <= wbyte;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      {carry_q, nib_q, uf0_q, bank_q, range_q, uf1_q} <= swdp_pkg::STATUS_RST[7:1];
    end else begin
      carry_q <= carry_d;
      nib_q <= nib_d;
      range_q <= range_d;
      // bank field written by software only
      if (wr_st) begin
        uf0_q <= wbyte[swdp_pkg::UFLAG0_POS];
        bank_q <= wbyte[swdp_pkg::BANK_HI_POS:swdp_pkg::BANK_LO_POS];
        uf1_q <= wbyte[swdp_pkg::UFLAG1_POS];
      end
    end
  end

  assign HRDATA_OUT = rdata_q;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT = swdp_pkg::HRESP_OKAY;
  assign PTR_ADDR_OUT = {ptr_hi_q, ptr_lo_q};
  assign WREG_ADDR_OUT = {bank_q, WREG_NUM_IN};
  assign STATUS_OUT = status;

  // reference values for the checks, built from the visible status word
  wire [7:0] chk_cin = {7'h00, (is_adc || is_sbb) && STATUS_OUT[swdp_pkg::CARRY_POS]};
  wire [7:0] chk_sum = opa + opb + chk_cin;
  wire [7:0] chk_dif = opa - opb - chk_cin;
  wire chk_add_ovf = (opa[7] == opb[7]) && (chk_sum[7] != opa[7]);
  wire chk_sub_ovf = (opa[7] != opb[7]) && (chk_dif[7] != opa[7]);
  wire chk_add_c7 = ({1'b0, opa} + {1'b0, opb} + {1'b0, chk_cin}) > 9'h0FF;
  wire chk_sub_b7 = {1'b0, opa} < ({1'b0, opb} + {1'b0, chk_cin});
  wire chk_add_c3 = ({1'b0, opa[3:0]} + {1'b0, opb[3:0]} + chk_cin[4:0]) > 5'h0F;
  wire chk_sub_b3 = {1'b0, opa[3:0]} < ({1'b0, opb[3:0]} + chk_cin[4:0]);

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  chk_ptr_low_write: assert property (
    wr_lo && !wr_hi |=> PTR_ADDR_OUT[7:0] == $past(HWDATA_IN[7:0])
      && PTR_ADDR_OUT[15:8] == $past(PTR_ADDR_OUT[15:8]))
    else $error("low pointer byte write wrong");
  chk_ptr_high_write: assert property (
    wr_hi && !wr_lo |=> PTR_ADDR_OUT[15:8] == $past(HWDATA_IN[7:0])
      && PTR_ADDR_OUT[7:0] == $past(PTR_ADDR_OUT[7:0]))
    else $error("high pointer byte write wrong");
  chk_user_flags: assert property (
    wr_st |=> STATUS_OUT[5] == $past(HWDATA_IN[5]) && STATUS_OUT[1] == $past(HWDATA_IN[1]))
    else $error("user flag write lost");

  chk_bank_write: assert property (
    wr_st |=> STATUS_OUT[4:3] == $past(HWDATA_IN[4:3]))
    else $error("bank field write lost");

  chk_bank_map: assert property (
    WREG_ADDR_OUT == 5'(8 * STATUS_OUT[4:3] + WREG_NUM_IN))
    else $error("bank address map wrong");

  chk_add_ov: assert property (
    req_v && adding |=> STATUS_OUT[2] == $past(chk_add_ovf))
    else $error("add overflow wrong");

  chk_borrow_ov: assert property (
    req_v && is_sbb |=> STATUS_OUT[2] == $past(chk_sub_ovf))
    else $error("subtract overflow wrong");

  chk_mul_ov: assert property (
    req_v && is_mult |=> STATUS_OUT[2] == (($past(opa) * $past(opb)) > 255) && !STATUS_OUT[7])
    else $error("multiply flags wrong");

  chk_div_ov: assert property (
    req_v && is_div |=> STATUS_OUT[2] == ($past(opb) == 0) && !STATUS_OUT[7])
    else $error("divide flags wrong");

  // parity follows the accumulator in every cycle, writes or not
  chk_parity_live: assert property (
    STATUS_OUT[0] == ^ACC_IN)
    else $error("parity not from accumulator");

  chk_add_carry: assert property (
    req_v && adding |=> STATUS_OUT[7] == $past(chk_add_c7))
    else $error("add carry wrong");

  chk_sub_carry: assert property (
    req_v && is_sbb |=> STATUS_OUT[7] == $past(chk_sub_b7))
    else $error("subtract borrow wrong");

  chk_nibble_carry: assert property (
    req_v && adding |=> STATUS_OUT[6] == $past(chk_add_c3))
    else $error("nibble carry wrong");

  chk_nibble_borrow: assert property (
    req_v && is_sbb |=> STATUS_OUT[6] == $past(chk_sub_b3))
    else $error("nibble borrow wrong");

  // multiply and divide leave the nibble flag alone
  chk_nibble_kept: assert property (
    req_v && (is_mult || is_div) && !wr_st |=> STATUS_OUT[6] == $past(STATUS_OUT[6]))
    else $error("nibble flag disturbed");

  // unused operation codes change no stored flag
  chk_bad_op_kept: assert property (
    req_v && !arith && !wr_st |=> STATUS_OUT[7:1] == $past(STATUS_OUT[7:1]))
    else $error("unused operation changed flags");

  // zero wait states and no error response, ever
  chk_bus_okay: assert property (
    HREADYOUT_OUT && HRESP_OUT == swdp_pkg::HRESP_OKAY)
    else $error("bus response not ready okay");

  // only the low byte lane carries data
  chk_rdata_upper: assert property (
    HRDATA_OUT[31:8] == 24'h000000)
    else $error("read data upper bits set");

  cov_ptr_write: cover property (wr_lo ##2 wr_hi);
  cov_div_zero: cover property (req_v && is_div && rng_div);
  cov_flag_race: cover property (wr_st && arith);
  cov_sub_overflow: cover property (req_v && is_sbb && rng_sub);
  cov_mult_overflow: cover property (req_v && is_mult && rng_mult);
endmodule
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rstn, hsel, hwrite, hrdy, hresp, carry, nib, rng, uf0, uf1;
  logic [1:0] htrans, rs;
  logic [2:0] hsize, wnum, bsz;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] acc, stat, lo, hi, v;
  logic [15:0] ptr;
  logic [4:0] wadr;
  swdp_pkg::swdp_alu_req_t req;
  int fails, cmp_count;
  swdp_core dut (.REF_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
    .HREADY_IN(hrdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy), .HRESP_OUT(hresp),
    .ALU_REQ_IN(req), .ACC_IN(acc), .WREG_NUM_IN(wnum), .PTR_ADDR_OUT(ptr),
    .WREG_ADDR_OUT(wadr), .STATUS_OUT(stat));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one single transfer; read data taken at the edge closing the data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= swdp_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    hsize <= bsz;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
    chk("hresp", {31'h00000000, hresp}, 32'h00000000);
    hsel <= 1'b0;
    #1;
  endtask
  task automatic wst(input logic [7:0] x);
    bus(1'b1, swdp_pkg::STATUS_ADDR, {24'h000000, x});
    {carry, nib, uf0, rs, rng, uf1} = x[7:1];
    bus(1'b0, swdp_pkg::STATUS_ADDR, 32'h00000000);
    chk("status_rd", rd, {24'h000000, carry, nib, uf0, rs, rng, uf1, ^acc});
  endtask
  task automatic alu(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
    logic c3, c6, c7, cin;
    @(posedge clk);
    req <= {1'b1, op, a, b};
    acc <= 8'($urandom);
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    cin = (op == 3'h1 || op == 3'h2) ? carry : 1'b0;
    c3 = ({1'b0, a[3:0]} + b[3:0] + cin) > 5'h0F;
    c6 = ({1'b0, a[6:0]} + b[6:0] + cin) > 8'h7F;
    c7 = ({1'b0, a} + b + cin) > 9'h0FF;
    if (op == 3'h2) begin
      c3 = {1'b0, a[3:0]} < b[3:0] + cin;
      c6 = {1'b0, a[6:0]} < b[6:0] + cin;
      c7 = {1'b0, a} < b + cin;
    end
    if (op <= 3'h2) begin
      {carry, nib, rng} = {c7, c3, c6 ^ c7};
    end else if (op == 3'h3) begin
      {carry, rng} = {1'b0, ({8'h00, a} * {8'h00, b}) > 16'h00FF};
    end else if (op == 3'h4) begin
      {carry, rng} = {1'b0, b == 8'h00};
    end
    chk("alu_status", stat, {carry, nib, uf0, rs, rng, uf1, ^acc});
  endtask
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    {rstn, hsel, hwrite, htrans, hsize, haddr, hwdata, acc, wnum, req} = '0;
    {carry, nib, rng, uf0, uf1, rs} = '0;
    bsz = swdp_pkg::HSIZE_WORD;
    fails = 0;
    cmp_count = 0;
    rd = $urandom(32'h01177A67);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    chk("ptr_rst", ptr, 32'h00000000);
    bus(1'b0, swdp_pkg::PTR_LO_ADDR, 32'h00000000);
    chk("lo_rst", rd, 32'h00000000);
    bus(1'b0, swdp_pkg::PTR_HI_ADDR, 32'h00000000);
    chk("hi_rst", rd, 32'h00000000);
    bus(1'b0, swdp_pkg::STATUS_ADDR, 32'h00000000);
    chk("st_rst", rd, 32'h00000000);
    bus(1'b0, 32'h00000000, 32'h00000000);
    chk("unmapped", rd, 32'h00000000);
    repeat (20) begin
      lo = 8'($urandom);
      hi = 8'($urandom);
      bus(1'b1, swdp_pkg::PTR_LO_ADDR, {24'h000000, lo});
      bus(1'b1, swdp_pkg::PTR_HI_ADDR, {24'h000000, hi});
      chk("ptr_out", ptr, {16'h0000, hi, lo});
      bus(1'b0, swdp_pkg::PTR_LO_ADDR, 32'h00000000);
      chk("lo_rd", rd, {24'h000000, lo});
      bus(1'b0, swdp_pkg::PTR_HI_ADDR, 32'h00000000);
      chk("hi_rd", rd, {24'h000000, hi});
    end
    // a byte-sized write must leave the pointer untouched
    bsz = 3'h0;
    bus(1'b1, swdp_pkg::PTR_LO_ADDR, {24'h000000, ~lo});
    bsz = swdp_pkg::HSIZE_WORD;
    chk("ptr_narrow", ptr, {16'h0000, hi, lo});
    for (int r = 0; r < 4; r++) begin
      v = 8'($urandom);
      v[4:3] = 2'(r);
      wst(v);
      for (int n = 0; n < 8; n++) begin
        @(posedge clk);
        wnum <= 3'(n);
        #1;
        chk("wreg_addr", wadr, 32'(r * 8 + n));
      end
    end
    // carry-in taken from the last software write or the last add, subtract, multiply or divide result
    for (int i = 0; i < 400; i++) begin
      if (i % 40 == 0)
        wst(8'($urandom));
      alu(3'($urandom_range(7, 0)), 8'($urandom), (i % 9 == 0) ? 8'h00 : 8'($urandom));
    end
    end_sim();
  end
endmodule
`default_nettype wire
